// >>> rtl/mwsp_port.sv
// Notes on behaviour
// (R1) single width shifts out on MOSI and in on MISO in the same clocks
// (R2) dual/quad bus: MOSI bit0, MISO bit1, line two bit2, line three bit3
// (R3) dual width moves two bits per clock, one direction only
// (R4) quad width moves four bits per clock, one direction only
// (R5) dual and quad only as master; slave is single full duplex
// (R6) master has four active-low select outputs, zero to three
// (R7) slave transfers are qualified by the select input; master ignores it
// (R8) all four polarity/phase pairs; polarity only sets the idle level
// (R9) phase picks which clock edge launches and which samples data
// (R10) the peer must use the same polarity and phase
// (R11) master takes new polarity and phase between transfers
// (R12) clock phases are whole ratio counts of the operating clock
// (R13) master clock period is high phase plus low phase
// (R14) select asserted six clock periods before the first clock
// (R15) select held six clock periods after the last clock
// (R16) master idles the clock six periods between bytes
// (R17) slave accepts bytes back to back with no idle
// (R18) an external master keeps its clock period at 50 ns or more
// (R19) at low interface supply keep master clock at or below 30 MHz
// (R20) operating clock selectable among 80, 60, 48 and 24 MHz
// (R21) slave clock at most a quarter of the operating clock
// (R22) phase 0 launches before the first edge; phase 1 on it
// (R23) selects are active low; bytes go most significant bit first
`timescale 1ns/1ps
`default_nettype none
module mwsp_port import mwsp_pkg::*; #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // configuration
  input  wire logic             role_master,
  input  wire logic [1:0]       width_sel,
  input  wire logic             dir_send,
  input  wire logic             cpol,
  input  wire logic             cpha,
  input  wire logic [1:0]       clk_sel,
  input  wire logic [DIV_W-1:0] div_ratio,
  input  wire logic [1:0]       ss_sel,
  // byte stream
  input  wire logic             tx_valid,
  input  wire logic [7:0]       tx_data,
  input  wire logic             tx_last,
  output logic                  tx_ready,
  output logic                  rx_valid,
  output logic [7:0]            rx_data,
  output logic                  busy,
  // serial pins
  input  wire logic             sck_i,
  output logic                  sck_o,
  output logic                  sck_oe_n,
  input  wire logic [3:0]       data_line_i,
  output logic [3:0]            data_line_o,
  output logic [3:0]            data_line_oe_n,
  output logic [3:0]            slave_select_out_n,
  input  wire logic             ss_in_n
);

  mwsp_state_e st_q;
  mwsp_state_e st_d;
  logic [4:0]  hc_q;
  logic [3:0]  edge_q;
  logic        sclk_q;
  logic [7:0]  sh_q;
  logic [7:0]  rx_sh_q;
  logic [7:0]  rx_data_q;
  logic        rx_valid_q;
  logic        last_q;
  logic        cpol_q;
  logic        cpha_q;
  logic        dir_q;
  logic [1:0]  width_q;
  logic [1:0]  ss_sel_q;
  logic [5:0]  s1_q;
  logic [5:0]  s2_q;
  logic [5:0]  s3_q;
  logic [5:0]  filt_q;
  logic        sck_prev_q;
  logic        ss_prev_q;
  logic [2:0]  s_lcnt_q;
  logic [2:0]  s_scnt_q;

  generate
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
      $error("mwsp_port: DIV_W must lie in 1..16");
    end
  endgenerate

  // one phase timer serves lead, bytes, gap and trail alike
  mwsp_tick_if #(.DIV_W(DIV_W)) tmr_if();

  mwsp_half_timer #(.DIV_W(DIV_W)) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tmr     (tmr_if.gen)
  );

  // pin synchroniser: a change counts once stages two and three agree
  // costs up to four cycles, so read data want phases well above that
  wire [5:0] pin_raw  = {ss_in_n, sck_i, data_line_i};
  wire [5:0] agree    = ~(s2_q ^ s3_q);
  wire [5:0] filt_d   = (agree & s3_q) | (~agree & filt_q);
  wire [3:0] in_d     = filt_q[3:0];
  wire       in_sck   = filt_q[4];
  wire       in_ss_n  = filt_q[5];

  // configuration and widths
  wire       cfg_open   = (st_q == MWSP_ST_IDLE) && (role_master || in_ss_n);
  wire       is_quad    = (width_q == MWSP_W_QUAD);
  wire       is_dual    = (width_q == MWSP_W_DUAL);
  wire       is_single  = !is_quad && !is_dual;
  wire [1:0] width_eff  = role_master ? width_sel : MWSP_W_SINGLE; // [R5]
  wire [2:0] bpc        = is_quad ? BITS_X4 : is_dual ? BITS_X2 : BITS_X1;
  wire [3:0] last_edge  = is_quad ? LAST_EDGE_X4 :
                          is_dual ? LAST_EDGE_X2 : LAST_EDGE_X1;

  // master timing
  wire       m_run      = role_master && (st_q != MWSP_ST_IDLE);
  wire       half_end   = tmr_if.half_end;
  wire       in_shift   = (st_q == MWSP_ST_SHIFT);
  wire       guard_done = (hc_q == GUARD_HALVES);
  assign tmr_if.sel = clk_sel;   // [R20]
  // low interface supply wants a ratio giving phases of 16.67 ns or more
  assign tmr_if.div = div_ratio; // [R12] [R19]
  // restart on every state change so no phase begins part-spent
  assign tmr_if.run = m_run && (st_d == st_q); // [R12]

  // master edge events: even edges lead, odd edges trail
  wire m_edge   = half_end && in_shift;
  wire m_samp   = m_edge && (edge_q[0] == cpha_q); // [R9] [R22]
  wire m_shift  = m_edge && (edge_q[0] != cpha_q) && (edge_q != 4'h0)
                  && (edge_q != last_edge); // [R22]
  wire byte_end = m_edge && (edge_q == last_edge);
  wire m_ready  = (st_q == MWSP_ST_IDLE) ||
                  ((st_q == MWSP_ST_GAP) && guard_done); // [R16]
  wire m_take   = role_master && tx_valid && m_ready;

  // counters restart on every state change so each stage counts from zero
  wire       st_move = (st_d != st_q);
  wire [4:0] hc_d    = st_move ? 5'h00 :
                       (half_end && !guard_done) ? hc_q + 5'h01 : hc_q;
  wire [3:0] edge_d  = st_move ? 4'h0 : m_edge ? edge_q + 4'h1 : edge_q;

  // slave edge events
  // slave edges come through the synchroniser, hence the clock limit
  wire s_act    = !role_master && !in_ss_n; // [R7]
  wire sck_rise = in_sck && !sck_prev_q;
  wire sck_fall = !in_sck && sck_prev_q;
  wire lead_e   = cpol_q ? sck_fall : sck_rise; // [R8]
  wire trail_e  = cpol_q ? sck_rise : sck_fall;
  wire ss_fall  = !in_ss_n && ss_prev_q;
  wire s_samp   = s_act && (cpha_q ? trail_e : lead_e); // [R9]
  wire s_launch = s_act && ((cpha_q ? lead_e : trail_e) ||
                  (ss_fall && !cpha_q)); // [R22]
  // with phase 0 the launch after a frame's last bit loads again: one spare byte is taken
  wire s_load   = s_launch && (s_lcnt_q == 3'h0);
  wire s_shift  = s_launch && (s_lcnt_q != 3'h0);
  wire s_done   = s_samp && (s_scnt_q == 3'h7); // [R17]

  // shared shifter controls
  wire       do_load  = m_take || s_load;
  wire       do_shift = m_shift || s_shift;
  wire       do_samp  = m_samp || s_samp;
  wire [7:0] load_val = (role_master || tx_valid) ? tx_data : SLAVE_FILL;
  wire       miso_in  = role_master ? in_d[1] : in_d[0]; // [R1]
  wire [7:0] rx_shift = is_quad ? {rx_sh_q[3:0], in_d} :
                        is_dual ? {rx_sh_q[5:0], in_d[1:0]} :
                        {rx_sh_q[6:0], miso_in}; // [R2] [R23]
  wire [7:0] rx_next  = do_samp ? rx_shift : rx_sh_q;
  wire       rx_fire  = role_master ? (byte_end && (is_single || !dir_q))
                                    : s_done; // [R3] [R4]

  // pin drive, oe low while driving
  // single keeps only the out line driven; the peer owns the in line
  wire       m_drive  = role_master && (st_q != MWSP_ST_IDLE);
  wire [3:0] m_dout   = is_quad ? sh_q[7:4] :
                        is_dual ? {2'b00, sh_q[7:6]} :
                        {3'b000, sh_q[7]}; // [R2] [R23]
  wire [3:0] m_oe_n   = !m_drive ? 4'hf :
                        is_quad ? (dir_q ? 4'h0 : 4'hf) :
                        is_dual ? (dir_q ? 4'hc : 4'hf) : 4'he; // [R3] [R4]
  wire [3:0] ss_onehot = 4'h1 << ss_sel_q;

  assign sck_o              = sclk_q;
  assign sck_oe_n           = !role_master;
  assign data_line_o        = role_master ? m_dout : {2'b00, sh_q[7], 1'b0};
  assign data_line_oe_n     = role_master ? m_oe_n : (s_act ? 4'hd : 4'hf);
  assign slave_select_out_n = m_drive ? ~ss_onehot : 4'hf; // [R6] [R23]
  assign tx_ready           = role_master ? m_ready : s_load;
  assign rx_valid           = rx_valid_q;
  assign rx_data            = rx_data_q;
  assign busy               = m_drive || s_act;

  // master sequencer
  // the gap holds the clock still until the next byte comes, however late
  always_comb begin
    st_d = st_q;
    case (st_q)
      MWSP_ST_IDLE: begin
        if (m_take) begin
          st_d = MWSP_ST_LEAD;
        end
      end
      MWSP_ST_LEAD: begin
        if (guard_done) begin
          st_d = MWSP_ST_SHIFT; // [R14]
        end
      end
      MWSP_ST_SHIFT: begin
        if (byte_end) begin
          st_d = last_q ? MWSP_ST_TRAIL : MWSP_ST_GAP;
        end
      end
      MWSP_ST_GAP: begin
        if (m_take) begin
          st_d = MWSP_ST_SHIFT; // [R16]
        end
      end
      MWSP_ST_TRAIL: begin
        if (guard_done) begin
          st_d = MWSP_ST_IDLE; // [R15]
        end
      end
      default: begin
        st_d = MWSP_ST_IDLE;
      end
    endcase
    if (!role_master) begin
      st_d = MWSP_ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q   <= PIN_SYNC_RST;
      s2_q   <= PIN_SYNC_RST;
      s3_q   <= PIN_SYNC_RST;
      filt_q <= PIN_SYNC_RST;
    end else begin
      s1_q   <= pin_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // polarity, phase, direction, width and select are only taken while idle, so a transfer never sees them move
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpol_q   <= 1'b0;
      cpha_q   <= 1'b0;
      dir_q    <= 1'b0;
      width_q  <= MWSP_W_SINGLE;
      ss_sel_q <= 2'h0;
    end else if (cfg_open) begin
      cpol_q   <= cpol;      // [R11]
      cpha_q   <= cpha;      // [R11]
      dir_q    <= dir_send;
      width_q  <= width_eff;
      ss_sel_q <= ss_sel;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q   <= MWSP_ST_IDLE;
      hc_q   <= 5'h00;
      edge_q <= 4'h0;
      last_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      hc_q   <= hc_d;
      edge_q <= edge_d;
      if (m_take) begin
        last_q <= tx_last;
      end
    end
  end

  // serial clock: idles at polarity, one toggle per phase end while shifting
  // idle level follows the live input so a new polarity shows no later than select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else if (st_q == MWSP_ST_IDLE) begin
      sclk_q <= cpol; // [R8]
    end else if (m_edge) begin
      sclk_q <= !sclk_q; // [R13]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_q <= SHIFT_RST;
    end else if (do_load) begin
      sh_q <= load_val;
    end else if (do_shift) begin
      // slave shifts one bit per edge whatever width was asked for
      sh_q <= role_master ? (sh_q << bpc) : (sh_q << 1); // [R23]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_sh_q    <= SHIFT_RST;
      rx_data_q  <= SHIFT_RST;
      rx_valid_q <= 1'b0;
    end else begin
      rx_sh_q    <= rx_next; // [R1]
      rx_valid_q <= rx_fire;
      // rx data move only on a whole byte, so a slow reader still sees it
      if (rx_fire) begin
        rx_data_q <= rx_next;
      end
    end
  end

  // slave bit counters restart whenever the select input is released
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
      ss_prev_q  <= 1'b1;
      s_lcnt_q   <= 3'h0;
      s_scnt_q   <= 3'h0;
    end else begin
      sck_prev_q <= in_sck;
      ss_prev_q  <= in_ss_n;
      if (!s_act) begin
        s_lcnt_q <= 3'h0; // [R7]
        s_scnt_q <= 3'h0;
      end else begin
        s_lcnt_q <= s_launch ? s_lcnt_q + 3'h1 : s_lcnt_q; // [R17]
        s_scnt_q <= s_samp ? s_scnt_q + 3'h1 : s_scnt_q;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/mwsp_pkg.sv
package mwsp_pkg;

  // reference operating clocks, in MHz, and the system clock they derive from
  localparam logic [7:0]  SYS_CLK_MHZ   = 8'h7d;
  localparam logic [7:0]  REF_80_MHZ    = 8'h50;
  localparam logic [7:0]  REF_60_MHZ    = 8'h3c;
  localparam logic [7:0]  REF_48_MHZ    = 8'h30;
  localparam logic [7:0]  REF_24_MHZ    = 8'h18;

  // operating clock select codes
  localparam logic [1:0]  CLK_SEL_80    = 2'h0;
  localparam logic [1:0]  CLK_SEL_60    = 2'h1;
  localparam logic [1:0]  CLK_SEL_48    = 2'h2;
  localparam logic [1:0]  CLK_SEL_24    = 2'h3;

  // select guard, select hold and inter-byte idle, in serial clock periods and half periods
  localparam logic [3:0]  GUARD_PERIODS = 4'h6;
  localparam logic [4:0]  GUARD_HALVES  = 5'h0c;

  // index of the last serial clock edge of one byte for each width
  localparam logic [3:0]  LAST_EDGE_X1  = 4'hf;
  localparam logic [3:0]  LAST_EDGE_X2  = 4'h7;
  localparam logic [3:0]  LAST_EDGE_X4  = 4'h3;

  // bits moved per serial clock for each width
  localparam logic [2:0]  BITS_X1       = 3'h1;
  localparam logic [2:0]  BITS_X2       = 3'h2;
  localparam logic [2:0]  BITS_X4       = 3'h4;

  // reset values and the slave fill byte
  localparam logic [7:0]  SHIFT_RST     = 8'h00;
  localparam logic [7:0]  SLAVE_FILL    = 8'h00;
  localparam logic [5:0]  PIN_SYNC_RST  = 6'h3f;

  typedef enum logic [1:0] {
    MWSP_W_SINGLE = 2'h0,
    MWSP_W_DUAL   = 2'h1,
    MWSP_W_QUAD   = 2'h2
  } mwsp_width_e;

  // gray coded along idle -> lead -> shift -> gap; shift -> trail moves two bits
  typedef enum logic [2:0] {
    MWSP_ST_IDLE  = 3'h0,
    MWSP_ST_LEAD  = 3'h1,
    MWSP_ST_SHIFT = 3'h3,
    MWSP_ST_GAP   = 3'h2,
    MWSP_ST_TRAIL = 3'h6
  } mwsp_state_e;

endpackage

// >>> rtl/mwsp_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mwsp_tick_if #(parameter int DIV_W = 8);
  logic [1:0]       sel;
  logic [DIV_W-1:0] div;
  logic             run;
  logic             half_end;

  modport gen  (input sel, input div, input run, output half_end);
  modport user (output sel, output div, output run, input half_end);
endinterface
`default_nettype wire

// >>> rtl/mwsp_half_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mwsp_half_timer import mwsp_pkg::*; #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input  wire logic     sys_clk,
  input  wire logic     rst,
  // timing request and phase-end pulse
  mwsp_tick_if.gen      tmr
);

  localparam int ACC_W = DIV_W + 8;

  generate
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
      $error("mwsp_half_timer: DIV_W must lie in 1..16");
    end
  endgenerate

  logic [ACC_W-1:0] acc_q;
  logic             half_q;
  logic [7:0]       ref_mhz;
  logic [DIV_W-1:0] div_eff;
  logic [ACC_W-1:0] target;
  logic [ACC_W-1:0] acc_next;
  logic             hit;

  // the accumulator gains the operating rate per system cycle, so one phase
  // spans ratio operating periods rounded up to whole system cycles
  assign ref_mhz  = (tmr.sel == CLK_SEL_80) ? REF_80_MHZ :
                    (tmr.sel == CLK_SEL_60) ? REF_60_MHZ :
                    (tmr.sel == CLK_SEL_48) ? REF_48_MHZ : REF_24_MHZ;
  assign div_eff  = (tmr.div == '0) ? DIV_W'(1) : tmr.div;
  assign target   = ACC_W'(div_eff) * ACC_W'(SYS_CLK_MHZ);
  assign acc_next = acc_q + ACC_W'(ref_mhz);
  assign hit      = tmr.run && (acc_next >= target);
  assign tmr.half_end = half_q;

  // remainder dropped on purpose: no phase ever comes out short
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q  <= '0;
      half_q <= 1'b0;
    end else begin
      acc_q  <= (!tmr.run || hit) ? '0 : acc_next;
      half_q <= hit;
    end
  end

endmodule
`default_nettype wire

// >>> test/mwsp_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module mwsp_port_props import mwsp_pkg::*; (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // configuration and stream
  input wire logic       role_master,
  input wire logic       cpol,
  input wire logic       tx_ready,
  input wire logic       rx_valid,
  input wire logic       busy,
  // pins
  input wire logic       sck_o,
  input wire logic       sck_oe_n,
  input wire logic [3:0] data_line_oe_n,
  input wire logic [3:0] slave_select_out_n
);
  logic [7:0] quiet_q;
  logic [7:0] quiet_d;
  logic       sck_prev_q;
  // cycles since the serial clock last moved, saturating
  assign quiet_d = (sck_o != sck_prev_q) ? 8'h00 :
                   quiet_q + {7'h00, quiet_q != 8'hff};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      quiet_q    <= 8'hff;
      sck_prev_q <= 1'b0;
    end else begin
      quiet_q    <= quiet_d;
      sck_prev_q <= sck_o;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sck_idle_a:
    assert property ((role_master && !busy && $stable(cpol))[*4]
      |-> sck_o == cpol) else $error("clock not at idle level");
  lead_quiet_a:
    assert property ($fell(&slave_select_out_n) |-> $stable(sck_o)[*8])
      else $error("clock moved right after select");
  trail_quiet_a:
    assert property (role_master && $rose(&slave_select_out_n)
      |-> quiet_q >= 8'h17) else $error("select released too early");
  sel_one_a:
    assert property (role_master && busy |-> $onehot(~slave_select_out_n))
      else $error("not exactly one select low");
  sel_steady_a:
    assert property (role_master && busy && $past(busy)
      |-> $stable(slave_select_out_n)) else $error("select moved");
  master_idle_a:
    assert property (role_master && !busy |-> tx_ready && !sck_oe_n &&
      data_line_oe_n == 4'hf && slave_select_out_n == 4'hf)
      else $error("master idle outputs wrong");
  slave_pins_a:
    assert property (!role_master |-> sck_oe_n && slave_select_out_n ==
      4'hf && data_line_oe_n == (busy ? 4'hd : 4'hf))
      else $error("slave pin drive wrong");
  rx_pulse_a:
    assert property (rx_valid |=> !rx_valid) else $error("rx pulse long");
endmodule
bind mwsp_port mwsp_port_props u_props (.sys_clk(sys_clk), .rst(rst),
  .role_master(role_master), .cpol(cpol), .tx_ready(tx_ready),
  .rx_valid(rx_valid), .busy(busy), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
  .data_line_oe_n(data_line_oe_n),
  .slave_select_out_n(slave_select_out_n));
`default_nettype wire

// >>> test/mwsp_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module mwsp_slave_model (
  // serial side
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic [3:0]  din,
  output logic [3:0]       dout,
  // setup
  input  wire logic        cpha,
  input  wire logic [1:0]  width_sel,
  input  wire logic [15:0] seed,
  output logic [15:0]      got
);
  logic [7:0] sh;
  logic [3:0] drv;
  logic [3:0] held = 4'h5;
  logic       second;
  int         e;
  int         w;
  assign w = (width_sel == 2'h2) ? 4 : (width_sel == 2'h1) ? 2 : 1;
  assign drv = (w == 4) ? sh[7:4] : (w == 2) ? {sh[5:4], sh[7:6]} :
               {sh[5:4], sh[7], sh[6]};
  // a released line shows the inverse of its last level, not a stale copy
  assign dout = sel_n ? held : drv;
  always @(posedge sel_n) held = ~drv;
  always @(negedge sel_n) begin
    e = 0;
    second = 1'b0;
    sh = seed[15:8];
  end
  always @(posedge sck or negedge sck) begin
    if (!sel_n) begin
      if ((e % 2) == cpha) begin
        case (w)
          4: got = {got[11:0], din};
          2: got = {got[13:0], din[1:0]};
          default: got = {got[14:0], din[0]};
        endcase
      end
      if (e == 16 / w - 1) begin
        second = !second;
        sh = second ? seed[7:0] : seed[15:8];
        e = 0;
      end else begin
        if ((e % 2) != cpha && e != 0) sh = sh << w;
        e = e + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/test_quad_spi_master_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_quad_spi_master_slave_port;
  import mwsp_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        role_master = 1'b1;
  logic [1:0]  width_sel = 2'h0;
  logic        dir_send = 1'b0;
  logic        cpol = 1'b0;
  logic        cpha = 1'b0;
  logic [1:0]  clk_sel = CLK_SEL_24;
  logic [7:0]  div_ratio = 8'h02;
  logic [1:0]  ss_sel = 2'h0;
  logic        tx_valid = 1'b0;
  logic [7:0]  tx_data = 8'h00;
  logic        tx_last = 1'b0;
  logic        sck_m = 1'b0;
  logic        ss_in_n = 1'b1;
  logic [3:0]  bdrv = 4'h0;
  logic [15:0] lf = 16'h85f0;
  logic [15:0] seed = 16'h0000;
  logic [15:0] mi;
  logic        sck_q;
  logic [7:0]  rxq[$];
  wire         tx_ready, rx_valid, busy, sck_o, sck_oe_n;
  wire [7:0]   rx_data;
  wire [3:0]   data_line_o, data_line_oe_n, slave_select_out_n, mdout;
  wire [3:0]   data_line_i;
  wire [15:0]  got;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          q = 0;
  int          lph;
  always #4 sys_clk = ~sys_clk;
  assign data_line_i = (~data_line_oe_n & data_line_o) |
                       (data_line_oe_n & (role_master ? mdout : bdrv));
  mwsp_port #(.DIV_W(8)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .role_master(role_master), .width_sel(width_sel), .dir_send(dir_send),
    .cpol(cpol), .cpha(cpha), .clk_sel(clk_sel), .div_ratio(div_ratio),
    .ss_sel(ss_sel), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .busy(busy), .sck_i(sck_m), .sck_o(sck_o),
    .sck_oe_n(sck_oe_n), .data_line_i(data_line_i),
    .data_line_o(data_line_o), .data_line_oe_n(data_line_oe_n),
    .slave_select_out_n(slave_select_out_n), .ss_in_n(ss_in_n));
  mwsp_slave_model u_model (.sck(sck_o), .sel_n(slave_select_out_n[ss_sel]),
    .din(data_line_i), .dout(mdout), .cpha(cpha), .width_sel(width_sel),
    .seed(seed), .got(got));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic int phase_len(input int d, input int r);
    return (d * int'(SYS_CLK_MHZ) + r - 1) / r;
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] g, input logic [15:0] x);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // what 0: wait for tx_ready high, 1: wait for busy low
  task automatic wait_for(input int what);
    int n;
    n = 0;
    @(negedge sys_clk);
    while ((what == 0) ? (tx_ready !== 1'b1) : (busy !== 1'b0)) begin
      @(negedge sys_clk);
      n++;
      if (n > 5000) begin
        check(16'(what), 16'hffff);
        stop_test;
      end
    end
  endtask
  task automatic mxfer(input logic [7:0] a, input logic [7:0] b);
    tx_data <= a;
    tx_valid <= 1'b1;
    wait_for(0);
    @(posedge sys_clk);
    tx_data <= b;
    tx_last <= 1'b1;
    wait_for(0);
    @(posedge sys_clk);
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
    wait_for(1);
    @(posedge sys_clk);
  endtask
  // long quiet stretches of the master clock are lead-in or byte gaps
  always @(negedge sys_clk) begin
    if (busy !== 1'b1 || role_master !== 1'b1) begin
      q = 0;
    end else if (sck_o !== sck_q) begin
      if (q > 2 * lph) begin
        check(16'(q >= 12 * lph), 16'h1);
      end else begin
        check(16'(q >= lph - 1), 16'h1);
      end
      q = 0;
    end else begin
      q++;
    end
    sck_q = sck_o;
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
  end
  initial begin
    lph = phase_len(2, int'(REF_24_MHZ));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // cfg 0 single, 1/2 dual send/receive, 3/4 quad send/receive
    for (int m = 0; m < 20; m++) begin
      repeat (8) lf = lfsr(lf);
      seed = lf;
      repeat (8) lf = lfsr(lf);
      cpol <= m[0];
      cpha <= m[1];
      ss_sel <= lf[1:0];
      width_sel <= (m < 4) ? 2'h0 : (m < 12) ? 2'h1 : 2'h2;
      dir_send <= (m / 4) % 2 == 1;
      repeat (2) @(posedge sys_clk);
      rxq.delete();
      mxfer(lf[15:8], lf[7:0]);
      if (m < 4 || (m / 4) % 2 == 1) check(got, lf);
      if ((m / 4) % 2 == 1) begin
        check(16'(rxq.size()), 16'h0);
      end else begin
        check(16'(rxq.size()), 16'h2);
        if (rxq.size() > 1) check({rxq[0], rxq[1]}, seed);
      end
      $display("master test %0d done", m);
    end
    // slave role, quad asked but single full duplex expected
    repeat (8) lf = lfsr(lf);
    role_master <= 1'b0;
    width_sel <= 2'h2;
    cpol <= 1'b0;
    cpha <= 1'b0;
    tx_data <= lf[15:8];
    tx_valid <= 1'b1;
    rxq.delete();
    repeat (4) @(posedge sys_clk);
    ss_in_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    // 24 cycle period: 192 ns, under a quarter of the operating clock
    for (int i = 15; i >= 0; i--) begin
      bdrv <= {lf[3:1], seed[i]};
      repeat (11) @(posedge sys_clk);
      @(negedge sys_clk);
      mi = {mi[14:0], data_line_i[1]};
      @(posedge sys_clk);
      sck_m <= 1'b1;
      repeat (12) @(posedge sys_clk);
      sck_m <= 1'b0;
      lf = lfsr(lf);
    end
    repeat (12) @(posedge sys_clk);
    ss_in_n <= 1'b1;
    tx_valid <= 1'b0;
    repeat (12) @(posedge sys_clk);
    check(16'(rxq.size()), 16'h2);
    if (rxq.size() > 1) check({rxq[0], rxq[1]}, seed);
    check(mi, {tx_data, tx_data});
    $display("slave test done");
    stop_test;
  end
endmodule
`default_nettype wire
